// ===== logic/vmi_map.vh
`ifndef VMI_MAP_VH
`define VMI_MAP_VH
// Register byte addresses
`define VMI_ADDR_MON1    12'h000
`define VMI_ADDR_MON2    12'h004
`define VMI_ADDR_LEVEL   12'h008
`define VMI_ADDR_CIRC    12'h00C
`define VMI_ADDR_CMP     12'h010
`define VMI_ADDR_EDGE    12'h014
`define VMI_ADDR_OSC     12'h018
// Monitor control fields
`define VMI_MC_IRQEN     0
`define VMI_MC_FDIS      1
`define VMI_MC_FLAG      2
`define VMI_MC_LEVEL     3
`define VMI_MC_SCLK_LO   4
`define VMI_MC_SCLK_HI   5
`define VMI_MC_COND      7
`define VMI_MC_RESET     8'h02
// Circuit control fields
`define VMI_CC_REF1      1
`define VMI_CC_IN1       2
`define VMI_CC_REF2      3
`define VMI_CC_IN2       4
`define VMI_CC_EN1       6
`define VMI_CC_EN2       7
// Comparator mode fields
`define VMI_CM_MONITOR1_IRQ_TYPE_SELECT   0
`define VMI_CM_MONITOR2_IRQ_TYPE_SELECT   1
`define VMI_CM_ROUTE     7
// Edge mode fields
`define VMI_EM_EDGE1     1
`define VMI_EM_EDGE2     2
// Oscillator stop bit and reset
`define VMI_OSC_STOP     0
`define VMI_OSC_RESET    8'h01
// Low-speed oscillator period, ns; clock period, ns; clock cycles per oscillator period
`define VMI_LOCO_NS      8000
`define VMI_CLK_NS       8
`define VMI_LOCO_CYC     ((`VMI_LOCO_NS + `VMI_CLK_NS - 1) / `VMI_CLK_NS)
`endif

// ===== logic/vmi_top.v
// Functional notes
// - Flag set before monitor 1 enable raises no request.
// - Monitor 1 disabled: grouped fields accept one combined write.
// - Flag set before monitor 2 enable raises no request.
// - Monitor 2 disabled: grouped fields accept one combined write.
// - Sampling clock field divides oscillator by 1, 2, 4 or 8.
// - Flags clear only on software write of 0; writing 1 keeps them.
`timescale 1ns/1ns
`include "vmi_map.vh"
module vmi_top (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Analog comparator outputs, asynchronous
  input  wire        cmpOut1,
  input  wire        cmpOut2,
  // Analog controls
  output wire [3:0]  detect1Level,
  output wire        ref1Sel,
  output wire        in1Sel,
  output wire        circ1En,
  output wire        ref2Sel,
  output wire        in2Sel,
  output wire        circ2En,
  output wire        oscStop,
  // Interrupt requests to the CPU
  output reg         irq1Req,
  output reg         irq2Req,
  output wire        irq1Type,
  output wire        irq2Type
);
  reg [1:0] rstSync_ff;
  wire      rstN = rstSync_ff[1];
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) rstSync_ff <= 2'h0;
    else rstSync_ff <= {rstSync_ff[0], 1'b1};
  end

  // Address phase capture
  reg        wrPend_ff;
  reg [11:0] addr_ff;
  wire       take = hsel & hready & htrans[1];
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPend_ff <= 1'b0;
      addr_ff   <= 12'h000;
    end else begin
      wrPend_ff <= take & hwrite;
      if (take) addr_ff <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  reg [7:0] mon1_ff, mon2_ff, level_ff, circ_ff, cmp_ff, edge_ff, osc_ff;
  wire wMon1 = wrPend_ff & (addr_ff == `VMI_ADDR_MON1);
  wire wMon2 = wrPend_ff & (addr_ff == `VMI_ADDR_MON2);

  // Comparator sync: three stages, change when stage 2 and 3 agree
  reg [2:0] sync1_ff, sync2_ff;
  reg       lvl1_ff, lvl2_ff;
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      lvl1_ff  <= 1'b0;
      lvl2_ff  <= 1'b0;
    end else begin
      sync1_ff <= {sync1_ff[1:0], cmpOut1};
      sync2_ff <= {sync2_ff[1:0], cmpOut2};
      if (sync1_ff[1] == sync1_ff[2]) lvl1_ff <= sync1_ff[2];
      if (sync2_ff[1] == sync2_ff[2]) lvl2_ff <= sync2_ff[2];
    end
  end

  // Sampling tick from low-speed oscillator, divided per field
  reg [15:0] locoCnt_ff;
  reg [2:0]  locoDiv_ff;
  wire       locoTick = (locoCnt_ff == `VMI_LOCO_CYC - 1);
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      locoCnt_ff <= 16'h0000;
      locoDiv_ff <= 3'h0;
    end else if (osc_ff[`VMI_OSC_STOP]) begin
      locoCnt_ff <= 16'h0000;
    end else begin
      locoCnt_ff <= locoTick ? 16'h0000 : locoCnt_ff + 16'h0001;
      if (locoTick) locoDiv_ff <= locoDiv_ff + 3'h1;
    end
  end

  function sampTick;
    input [1:0] sel;
    input       tick;
    input [2:0] div;
    begin
      case (sel)
        2'h0:    sampTick = tick;
        2'h1:    sampTick = tick & (div[0] == 1'b1);
        2'h2:    sampTick = tick & (div[1:0] == 2'h3);
        default: sampTick = tick & (div == 3'h7);
      endcase
    end
  endfunction

  wire samp1 = sampTick(mon1_ff[`VMI_MC_SCLK_HI:`VMI_MC_SCLK_LO], locoTick, locoDiv_ff);
  wire samp2 = sampTick(mon2_ff[`VMI_MC_SCLK_HI:`VMI_MC_SCLK_LO], locoTick, locoDiv_ff);

  // Digital filter: output moves after two equal samples
  reg [1:0] flt1_ff, flt2_ff;
  reg       fo1_ff, fo2_ff, prev1_ff, prev2_ff;
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flt1_ff <= 2'h0;
      flt2_ff <= 2'h0;
      fo1_ff  <= 1'b0;
      fo2_ff  <= 1'b0;
    end else begin
      if (samp1) begin
        flt1_ff <= {flt1_ff[0], lvl1_ff};
        if (flt1_ff[0] == lvl1_ff) fo1_ff <= lvl1_ff;
      end
      if (samp2) begin
        flt2_ff <= {flt2_ff[0], lvl2_ff};
        if (flt2_ff[0] == lvl2_ff) fo2_ff <= lvl2_ff;
      end
    end
  end
  // Bypass path keeps working without the oscillator, for stop-mode wake
  wire src1 = mon1_ff[`VMI_MC_FDIS] ? lvl1_ff : fo1_ff;
  wire src2 = mon2_ff[`VMI_MC_FDIS] ? lvl2_ff : fo2_ff;

  function edgeHit;
    input cur;
    input prv;
    input both;
    input cond;
    begin
      if (both) edgeHit = cur ^ prv;
      else if (cond) edgeHit = prv & ~cur;
      else edgeHit = cur & ~prv;
    end
  endfunction

  wire hit1 = circ_ff[`VMI_CC_EN1] & edgeHit(src1, prev1_ff, edge_ff[`VMI_EM_EDGE1],
                                               mon1_ff[`VMI_MC_COND]);
  wire hit2 = circ_ff[`VMI_CC_EN2] & edgeHit(src2, prev2_ff, edge_ff[`VMI_EM_EDGE2],
                                               mon2_ff[`VMI_MC_COND]);

  // Flag: set wins; write of 0 clears, write of 1 keeps
  function [7:0] monNext;
    input [7:0] cur;
    input       wr;
    input [7:0] wd;
    input       hit;
    begin
      monNext = cur;
      if (wr) begin
        monNext = wd;
        monNext[`VMI_MC_FLAG] = cur[`VMI_MC_FLAG] & wd[`VMI_MC_FLAG];
      end
      if (hit) monNext[`VMI_MC_FLAG] = 1'b1;
    end
  endfunction

  wire [7:0] nxt_mon1 = monNext(mon1_ff, wMon1, hwdata[7:0], hit1);
  wire [7:0] nxt_mon2 = monNext(mon2_ff, wMon2, hwdata[7:0], hit2);

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mon1_ff  <= `VMI_MC_RESET;
      mon2_ff  <= `VMI_MC_RESET;
      level_ff <= 8'h00;
      circ_ff  <= 8'h00;
      cmp_ff   <= 8'h00;
      edge_ff  <= 8'h00;
      osc_ff   <= `VMI_OSC_RESET;
      prev1_ff <= 1'b0;
      prev2_ff <= 1'b0;
      irq1Req  <= 1'b0;
      irq2Req  <= 1'b0;
    end else begin
      mon1_ff  <= nxt_mon1;
      mon2_ff  <= nxt_mon2;
      prev1_ff <= src1;
      prev2_ff <= src2;
      // Request only from a fresh hit while enabled; stale flag gives none
      irq1Req  <= hit1 & mon1_ff[`VMI_MC_IRQEN] & cmp_ff[`VMI_CM_ROUTE];
      irq2Req  <= hit2 & mon2_ff[`VMI_MC_IRQEN] & cmp_ff[`VMI_CM_ROUTE];
      if (wrPend_ff) begin
        // Whole-byte writes let grouped steps land together
        case (addr_ff)
          `VMI_ADDR_LEVEL: level_ff <= hwdata[7:0];
          `VMI_ADDR_CIRC:  circ_ff  <= hwdata[7:0];
          `VMI_ADDR_CMP:   cmp_ff   <= hwdata[7:0];
          `VMI_ADDR_EDGE:  edge_ff  <= hwdata[7:0];
          `VMI_ADDR_OSC:   osc_ff   <= hwdata[7:0];
          default:         edge_ff  <= edge_ff;
        endcase
      end
    end
  end

  // Read data registered at the edge that ends the address phase, held through the data phase
  always @(posedge clk or negedge rstN) begin
    if (!rstN) hrdata <= 32'h00000000;
    else if (take & ~hwrite) begin
      case (haddr)
        `VMI_ADDR_MON1:  hrdata <= {24'h000000, mon1_ff};
        `VMI_ADDR_MON2:  hrdata <= {24'h000000, mon2_ff};
        `VMI_ADDR_LEVEL: hrdata <= {24'h000000, level_ff};
        `VMI_ADDR_CIRC:  hrdata <= {24'h000000, circ_ff};
        `VMI_ADDR_CMP:   hrdata <= {24'h000000, cmp_ff};
        `VMI_ADDR_EDGE:  hrdata <= {24'h000000, edge_ff};
        `VMI_ADDR_OSC:   hrdata <= {24'h000000, osc_ff};
        default:         hrdata <= 32'h00000000;
      endcase
    end
  end

  assign detect1Level = level_ff[3:0];
  assign ref1Sel  = circ_ff[`VMI_CC_REF1];
  assign in1Sel   = circ_ff[`VMI_CC_IN1];
  assign circ1En  = circ_ff[`VMI_CC_EN1];
  assign ref2Sel  = circ_ff[`VMI_CC_REF2];
  assign in2Sel   = circ_ff[`VMI_CC_IN2];
  assign circ2En  = circ_ff[`VMI_CC_EN2];
  assign oscStop  = osc_ff[`VMI_OSC_STOP];
  assign irq1Type = cmp_ff[`VMI_CM_MONITOR1_IRQ_TYPE_SELECT];
  assign irq2Type = cmp_ff[`VMI_CM_MONITOR2_IRQ_TYPE_SELECT];
endmodule

// ===== tb/vmi_cmp_model.sv
`timescale 1ns/1ns
module vmi_cmp_model #(parameter SETTLE = 16) (
  // Clock and commanded levels
  input  wire       clk,
  input  wire [1:0] lvl,
  input  wire [1:0] en,
  // Comparator outputs
  output reg  [1:0] cmp
);
  reg [4:0] cnt [0:1];
  integer   i;
  initial cmp = 2'h0;
  // Off or unsettled comparator chatters, so no stale level is trusted
  always @(posedge clk) begin
    for (i = 0; i < 2; i = i + 1) begin
      cnt[i] <= en[i] ? cnt[i] + (cnt[i] != SETTLE) : 5'h0;
      cmp[i] <= (cnt[i] == SETTLE) ? lvl[i] : ~cmp[i];
    end
  end
endmodule

// ===== tb/vmi_top_sva.sv
`timescale 1ns/1ns
`include "vmi_map.vh"
module vmi_top_sva (
  // Clock, reset and bus
  input wire        clk,
  input wire        rst_b,
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  // Observed outputs
  input wire        ref1Sel,
  input wire        in1Sel,
  input wire        circ1En,
  input wire        ref2Sel,
  input wire        in2Sel,
  input wire        circ2En,
  input wire        irq1Req,
  input wire        irq2Req,
  input wire        irq1Type,
  input wire        irq2Type
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire wr  = hsel && htrans[1] && hwrite;
  wire wrC = wr && haddr == `VMI_ADDR_CIRC;
  wire wrM = wr && haddr == `VMI_ADDR_CMP;
  a_circ1_group: assert property (wrC |-> ##2 {ref1Sel, in1Sel, circ1En} ==
    {$past(hwdata[1]), $past(hwdata[2]), $past(hwdata[6])}) else $error("circ1 group");
  a_circ2_group: assert property (wrC |-> ##2 {ref2Sel, in2Sel, circ2En} ==
    {$past(hwdata[3]), $past(hwdata[4]), $past(hwdata[7])}) else $error("circ2 group");
  a_cmp_types: assert property (wrM |-> ##2 {irq2Type, irq1Type} == $past(hwdata[1:0]))
    else $error("irq types");
  a_circ_hold: assert property (!wrC |-> ##2
    $stable({ref1Sel, in1Sel, circ1En, ref2Sel, in2Sel, circ2En})) else $error("circ drift");
  a_irq1_cause: assert property (irq1Req |-> circ1En ##1 !irq1Req) else $error("irq1");
  a_irq2_cause: assert property (irq2Req |-> circ2En ##1 !irq2Req) else $error("irq2");
  c_irq1: cover property (irq1Req);
  c_irq2: cover property (irq2Req);
  c_circ_wr: cover property (wrC);
endmodule
bind vmi_top vmi_top_sva u_sva (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .ref1Sel, .in1Sel, .circ1En, .ref2Sel, .in2Sel, .circ2En, .irq1Req, .irq2Req, .irq1Type,
  .irq2Type);

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`include "vmi_map.vh"
module tb_top;
  reg         clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg  [11:0] haddr = 12'h000;
  reg  [1:0]  htrans = 2'h0, lvl = 2'h0;
  reg  [31:0] hwdata = 32'h0, rd;
  wire [1:0]  cmp, en, req, typ;
  wire [31:0] hrdata;
  wire [3:0]  lvlSel;
  wire        hreadyout, hresp, osc, r1, i1, r2, i2;
  integer     mismatches = 0, n_compared = 0, irqCnt [0:1];
  always #4 clk = ~clk;
  vmi_top u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cmpOut1(cmp[0]), .cmpOut2(cmp[1]), .detect1Level(lvlSel),
    .ref1Sel(r1), .in1Sel(i1), .circ1En(en[0]), .ref2Sel(r2), .in2Sel(i2), .circ2En(en[1]),
    .oscStop(osc), .irq1Req(req[0]), .irq2Req(req[1]), .irq1Type(typ[0]), .irq2Type(typ[1]));
  vmi_cmp_model u_cmp (.clk(clk), .lvl(lvl), .en(en), .cmp(cmp));
  always @(posedge clk) begin
    if (req[0]) irqCnt[0] = irqCnt[0] + 1;
    if (req[1]) irqCnt[1] = irqCnt[1] + 1;
  end
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp, input string m);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task rdy;
    integer n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge clk);
      n = n + 1;
    end
    if (n == 50) begin
      chk(32'h0, 32'h1, "hang");
      print_verdict;
    end
  endtask
  // Read data is taken at the edge that ends the data phase
  task bus(input w, input [11:0] a, input [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task t_group;
    chk(osc, 32'h1, "osc stop reset");
    bus(1'b0, 12'h01C, 32'h0);
    chk(rd, 32'h0, "unmapped");
    chk(hresp, 32'h0, "okay response");
    bus(1'b1, `VMI_ADDR_LEVEL, 32'h0000000A);
    bus(1'b1, `VMI_ADDR_CIRC, 32'h000000D0);
    cyc(20);
    bus(1'b1, `VMI_ADDR_CMP, 32'h00000081);
    cyc(2);
    chk({lvlSel, r1, i1, en[0], r2, i2, en[1], typ}, 32'hA2D, "grouped");
    cyc(30);
    $display("test group done");
  endtask
  task t_pre(input integer ch, input cond);
    reg [11:0] a;
    a = 12'(4 * ch);
    lvl[ch] <= cond;
    cyc(30);
    bus(1'b1, a, {24'h0, cond, 7'h02});
    lvl[ch] <= ~cond;
    cyc(30);
    bus(1'b0, a, 32'h0);
    chk(rd[2], 32'h1, "flag set");
    bus(1'b1, a, {24'h0, cond, 7'h07});
    cyc(30);
    bus(1'b0, a, 32'h0);
    chk(rd[2], 32'h1, "flag kept");
    chk(irqCnt[ch], 32'h0, "stale request");
    bus(1'b1, a, {24'h0, cond, 7'h03});
    bus(1'b0, a, 32'h0);
    chk(rd[2], 32'h0, "flag clear");
    lvl[ch] <= cond;
    cyc(30);
    lvl[ch] <= ~cond;
    cyc(30);
    chk(irqCnt[ch], 32'h1, "fresh request");
    bus(1'b1, `VMI_ADDR_EDGE, 32'h2 << ch);
    lvl[ch] <= cond;
    cyc(30);
    chk(irqCnt[ch], 32'h2, "both edges");
    bus(1'b1, `VMI_ADDR_EDGE, 32'h0);
    $display("test preflag %0d done", ch);
  endtask
  task t_filt;
    integer s, n, n0;
    bus(1'b1, `VMI_ADDR_OSC, 32'h0);
    cyc(1);
    chk(osc, 32'h0, "osc running");
    for (s = 0; s < 4; s = s + 1) begin
      lvl[0] <= 1'b0;
      bus(1'b1, 12'h000, {26'h0, s[1:0], 4'h0});
      // Margin lets the old filtered level fall before enabling
      cyc((2000 << s) + 20);
      bus(1'b1, 12'h000, {26'h0, s[1:0], 4'h1});
      n0 = irqCnt[0];
      lvl[0] <= 1'b1;
      n = 0;
      while (irqCnt[0] == n0 && n < (2000 << s) + 100) begin
        @(posedge clk);
        n = n + 1;
      end
      chk(n >= (1000 << s) && n <= (2000 << s) + 40, 32'h1, "filter delay");
      if (n >= (2000 << s) + 100)
        print_verdict;
    end
    $display("test filter done");
  endtask
  initial begin
    irqCnt[0] = 0;
    irqCnt[1] = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    cyc(3);
    t_group;
    t_pre(0, 1'b0);
    t_pre(1, 1'b1);
    t_filt;
    print_verdict;
  end
endmodule
